// file: verilog/status_pulse_controller.sv
`timescale 1ns/1ps
module status_pulse_controller #(
   parameter longint PHASE_CYCLES   = pulse_status_pkg::PHASE_CYCLES,
   parameter longint QUIET_CYCLES   = pulse_status_pkg::QUIET_CYCLES,
   parameter longint TIMEOUT_CYCLES = pulse_status_pkg::TIMEOUT_CYCLES
) (
   input  wire logic                      sys_clk_in,
   input  wire logic                      arst_n_in,
   status_link_if.controller              link,
   input  wire logic                      send_in,
   input  wire logic                      kind_status_in,
   input  wire logic                      kind_ack_in,
   input  wire logic                      kind_undefined_in,
   output logic                           ready_out,
   output logic                           result_valid_out,
   output pulse_status_pkg::status_t      result_out,
   output logic [4:0]                     edge_count_out,
   output logic                           timeout_out,
   output logic                           link_lost_out,
   output logic                           line_fault_out
);

   typedef enum logic [1:0] {C_QUIET, C_READY, C_WAIT, C_COUNT} cphase_t;

   typedef struct packed {
      logic [1:0]                sync;
      logic                      prev;
      cphase_t                   phase;
      logic [31:0]               timer;
      logic [31:0]               low_timer;
      logic [4:0]                count;
      logic                      probing;
      logic                      probe_pending;
      logic                      cmd_valid;
      logic                      cmd_status;
      logic                      cmd_ack;
      logic                      cmd_undef;
      logic                      res_valid;
      pulse_status_pkg::status_t res;
      logic [4:0]                res_count;
      logic                      tout;
      logic                      lost;
      logic                      lfault;
   } cstate_t;

   cstate_t r;
   cstate_t next_r;
   logic    line;

   assign line = r.sync[1];

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r           = r;
      next_r.sync      = {r.sync[0], link.status_line};
      next_r.prev      = line;
      next_r.cmd_valid = 1'b0;
      next_r.res_valid = 1'b0;
      // R14 steady low is a fault
      if (line) begin
         next_r.low_timer = 32'h0000_0000;
         next_r.lfault    = 1'b0;
      end else if (r.low_timer >= 32'(2 * PHASE_CYCLES)) begin
         next_r.lfault = 1'b1;
      end else begin
         next_r.low_timer = r.low_timer + 32'h0000_0001;
      end
      unique case (r.phase)
         // R16 wait for quiet high
         C_QUIET: begin
            if (!line) begin
               next_r.timer = 32'h0000_0000;
            end else if (r.timer >= 32'(QUIET_CYCLES + 1)) begin
               next_r.phase = C_READY;
            end else begin
               next_r.timer = r.timer + 32'h0000_0001;
            end
         end
         C_READY: begin
            if (r.probe_pending || send_in) begin
               next_r.cmd_valid     = 1'b1;
               next_r.cmd_status    = r.probe_pending ? 1'b1 : kind_status_in;
               next_r.cmd_ack       = r.probe_pending ? 1'b0 : kind_ack_in;
               next_r.cmd_undef     = r.probe_pending ? 1'b0 : kind_undefined_in;
               next_r.probing       = r.probe_pending;
               next_r.probe_pending = 1'b0;
               next_r.timer         = 32'h0000_0000;
               next_r.count         = 5'h00;
               next_r.phase         = C_WAIT;
            end
         end
         // R2 R13 wait for response with time-out
         C_WAIT: begin
            if (r.prev == 1'b0 && line) begin
               next_r.count = 5'h01;
               next_r.timer = 32'h0000_0000;
               next_r.phase = C_COUNT;
            end else if (r.timer >= 32'(TIMEOUT_CYCLES - 1)) begin
               next_r.timer = 32'h0000_0000;
               if (r.probing) begin
                  next_r.lost = 1'b1;
               end else begin
                  next_r.tout          = 1'b1;
                  next_r.probe_pending = 1'b1;
               end
               next_r.phase = C_QUIET;
            end else if (!line && r.prev) begin
               next_r.timer = r.timer;
            end else begin
               next_r.timer = r.timer + 32'h0000_0001;
            end
         end
         // R4 R18 count rising edges until quiet
         C_COUNT: begin
            if (r.prev == 1'b0 && line) begin
               next_r.count = r.count + 5'h01;
               next_r.timer = 32'h0000_0000;
            end else if (!line) begin
               next_r.timer = 32'h0000_0000;
            end else if (r.timer >= 32'(2 * PHASE_CYCLES)) begin
               next_r.timer     = 32'h0000_0000;
               next_r.res_valid = 1'b1;
               next_r.res_count = r.count;
               next_r.res       = pulse_status_pkg::edges_status(r.count);
               next_r.tout      = 1'b0;
               next_r.lost      = 1'b0;
               next_r.phase     = C_QUIET;
            end else begin
               next_r.timer = r.timer + 32'h0000_0001;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r <= '{sync: 2'h3, prev: 1'b1, phase: C_QUIET, res: pulse_status_pkg::ST_NONE, default: '0};
      end else begin
         r <= next_r;
      end
   end

   assign link.cmd_valid          = r.cmd_valid;
   assign link.cmd_status_request = r.cmd_status;
   assign link.cmd_ack            = r.cmd_ack;
   assign link.cmd_undefined      = r.cmd_undef;
   assign ready_out               = (r.phase == C_READY) && !r.probe_pending;
   assign result_valid_out        = r.res_valid;
   assign result_out              = r.res;
   assign edge_count_out          = r.res_count;
   assign timeout_out             = r.tout;
   assign link_lost_out           = r.lost;
   assign line_fault_out          = r.lfault;

endmodule : status_pulse_controller

// file: common/pulse_status_pkg.sv
package pulse_status_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint PHASE_MS        = 100;
   localparam longint QUIET_MS        = 500;
   localparam longint TIMEOUT_S       = 30;
   localparam longint PHASE_CYCLES    = CLK_HZ * PHASE_MS / 1000;
   localparam longint QUIET_CYCLES    = CLK_HZ * QUIET_MS / 1000 + 1;
   localparam longint TIMEOUT_CYCLES  = CLK_HZ * TIMEOUT_S;
   localparam int     CNT_W           = 32;

   // ------------------------------------------------------------
   // Edge counts per status
   // ------------------------------------------------------------
   localparam logic [4:0] EDGES_CANCELLED    = 5'h01;
   localparam logic [4:0] EDGES_STROKE_OK    = 5'h02;
   localparam logic [4:0] EDGES_SOON_EMPTY   = 5'h03;
   localparam logic [4:0] EDGES_OVERPRESSURE = 5'h04;
   localparam logic [4:0] EDGES_EMPTY        = 5'h0C;
   localparam logic [4:0] EDGES_SUPPLY       = 5'h0E;
   localparam logic [4:0] EDGES_INTERNAL     = 5'h0F;
   localparam logic [4:0] EDGES_UNDEFINED    = 5'h10;

   typedef enum logic [3:0] {
      ST_CANCELLED,
      ST_STROKE_OK,
      ST_SOON_EMPTY,
      ST_OVERPRESSURE,
      ST_EMPTY,
      ST_SUPPLY,
      ST_INTERNAL,
      ST_UNDEFINED,
      ST_NONE
   } status_t;

   function automatic logic [4:0] status_edges(input status_t s);
      unique case (s)
         ST_CANCELLED:    status_edges = EDGES_CANCELLED;
         ST_STROKE_OK:    status_edges = EDGES_STROKE_OK;
         ST_SOON_EMPTY:   status_edges = EDGES_SOON_EMPTY;
         ST_OVERPRESSURE: status_edges = EDGES_OVERPRESSURE;
         ST_EMPTY:        status_edges = EDGES_EMPTY;
         ST_SUPPLY:       status_edges = EDGES_SUPPLY;
         ST_INTERNAL:     status_edges = EDGES_INTERNAL;
         ST_UNDEFINED:    status_edges = EDGES_UNDEFINED;
         default:         status_edges = 5'h00;
      endcase
   endfunction : status_edges

   function automatic status_t edges_status(input logic [4:0] n);
      unique case (n)
         EDGES_CANCELLED:    edges_status = ST_CANCELLED;
         EDGES_STROKE_OK:    edges_status = ST_STROKE_OK;
         EDGES_SOON_EMPTY:   edges_status = ST_SOON_EMPTY;
         EDGES_OVERPRESSURE: edges_status = ST_OVERPRESSURE;
         EDGES_EMPTY:        edges_status = ST_EMPTY;
         EDGES_SUPPLY:       edges_status = ST_SUPPLY;
         EDGES_INTERNAL:     edges_status = ST_INTERNAL;
         EDGES_UNDEFINED:    edges_status = ST_UNDEFINED;
         default:            edges_status = ST_NONE;
      endcase
   endfunction : edges_status

endpackage : pulse_status_pkg

// file: common/status_link_if.sv
`timescale 1ns/1ps
interface status_link_if;
   logic status_line;
   logic cmd_valid;
   logic cmd_status_request;
   logic cmd_ack;
   logic cmd_undefined;

   modport device (
      output status_line,
      input  cmd_valid,
      input  cmd_status_request,
      input  cmd_ack,
      input  cmd_undefined
   );

   modport controller (
      input  status_line,
      output cmd_valid,
      output cmd_status_request,
      output cmd_ack,
      output cmd_undefined
   );
endinterface : status_link_if

// file: verilog/status_pulse_device.sv
`timescale 1ns/1ps
// Contract
// R1: One response per command, after action done.
// R2: Controller waits for each response.
// R3: Line idles high, returns high after.
// R4: Controller counts rising edges only.
// R5: Pulses repeat at 5 Hz.
// R6: One cancelled, two OK, three soon-empty.
// R7: Four edges overpressure, pending until acknowledged.
// R8: Fourteen edges supply fault, pending until acknowledged.
// R9: Twelve edges cartridge empty, clears after refill.
// R10: Fifteen edges internal device fault.
// R11: Sixteen edges for undefined command.
// R12: Response begins within 30 seconds.
// R13: Controller flags time-out, probes, then link loss.
// R14: Controller treats steady low as fault.
// R15: Status request replays latest stroke response.
// R16: Controller waits 500 ms high; device ignores.
// R17: 100 ms low then 100 ms high.
// R18: Controller ends response after quiet period.
module status_pulse_device #(
   parameter longint PHASE_CYCLES = pulse_status_pkg::PHASE_CYCLES,
   parameter longint QUIET_CYCLES = pulse_status_pkg::QUIET_CYCLES
) (
   input  wire logic                      sys_clk_in,
   input  wire logic                      arst_n_in,
   status_link_if.device                  link,
   input  wire logic                      action_done_in,
   input  wire pulse_status_pkg::status_t action_status_in,
   input  wire logic                      refill_done_in,
   input  wire logic                      ack_check_ok_in,
   output logic                           busy_out,
   output logic                           error_pending_out
);

   typedef enum logic [1:0] {S_IDLE, S_WAIT_ACTION, S_LOW, S_HIGH} phase_t;

   typedef struct packed {
      phase_t                   phase;
      logic [31:0]              timer;
      logic [4:0]               edges_left;
      pulse_status_pkg::status_t last;
      pulse_status_pkg::status_t pending;
      logic                     line;
      logic                     quiet_ok;
   } state_t;

   state_t r;
   state_t next_r;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      // R9 auto clear
      if (refill_done_in && r.pending == pulse_status_pkg::ST_EMPTY) begin
         next_r.pending = pulse_status_pkg::ST_NONE;
      end
      unique case (r.phase)
         S_IDLE: begin
            next_r.line = 1'b1;
            if (!r.quiet_ok) begin
               if (r.timer >= 32'(QUIET_CYCLES - 1)) begin
                  next_r.quiet_ok = 1'b1;
               end else begin
                  next_r.timer = r.timer + 32'h0000_0001;
               end
            // R16 commands ignored until quiet
            end else if (link.cmd_valid) begin
               next_r.quiet_ok = 1'b0;
               next_r.timer    = 32'h0000_0000;
               // R11 undefined command
               if (link.cmd_undefined) begin
                  next_r.edges_left = pulse_status_pkg::status_edges(pulse_status_pkg::ST_UNDEFINED);
                  next_r.phase      = S_LOW;
               // R15 replay latest stroke
               end else if (link.cmd_status_request) begin
                  next_r.edges_left = pulse_status_pkg::status_edges(r.last);
                  next_r.phase      = S_LOW;
               // R7 R8 acknowledge clears pending fault when ack_check_ok_in is set
               end else if (link.cmd_ack && (r.pending == pulse_status_pkg::ST_OVERPRESSURE ||
                                             r.pending == pulse_status_pkg::ST_SUPPLY)) begin
                  if (ack_check_ok_in) begin
                     next_r.pending    = pulse_status_pkg::ST_NONE;
                     next_r.last       = pulse_status_pkg::ST_STROKE_OK;
                     next_r.edges_left = pulse_status_pkg::status_edges(pulse_status_pkg::ST_STROKE_OK);
                  end else begin
                     next_r.edges_left = pulse_status_pkg::status_edges(r.pending);
                  end
                  next_r.phase = S_LOW;
               // R7 R8 R10 pending fault blocks other commands
               end else if (r.pending != pulse_status_pkg::ST_NONE) begin
                  next_r.edges_left = pulse_status_pkg::status_edges(r.pending);
                  next_r.phase      = S_LOW;
               end else begin
                  next_r.phase = S_WAIT_ACTION;
               end
            end
         end
         // R1 R6 R12 answer after action
         S_WAIT_ACTION: begin
            if (action_done_in) begin
               next_r.last       = action_status_in;
               next_r.edges_left = pulse_status_pkg::status_edges(action_status_in);
               next_r.phase      = S_LOW;
               if (action_status_in == pulse_status_pkg::ST_OVERPRESSURE ||
                   action_status_in == pulse_status_pkg::ST_SUPPLY ||
                   action_status_in == pulse_status_pkg::ST_EMPTY ||
                   action_status_in == pulse_status_pkg::ST_INTERNAL) begin
                  next_r.pending = action_status_in;
               end
            end
         end
         // R5 R17 100 ms low phase
         S_LOW: begin
            next_r.line = 1'b0;
            // First cycle after S_IDLE only pulls the line low
            if (r.line) begin
               next_r.timer = 32'h0000_0000;
            end else if (r.timer >= 32'(PHASE_CYCLES - 1)) begin
               next_r.timer      = 32'h0000_0000;
               next_r.line       = 1'b1;
               next_r.edges_left = r.edges_left - 5'h01;
               next_r.phase      = S_HIGH;
            end else begin
               next_r.timer = r.timer + 32'h0000_0001;
            end
         end
         // R3 R17 high phase, then rest high
         S_HIGH: begin
            next_r.line = 1'b1;
            if (r.timer >= 32'(PHASE_CYCLES - 1)) begin
               next_r.timer = 32'h0000_0000;
               next_r.phase = (r.edges_left == 5'h00) ? S_IDLE : S_LOW;
               next_r.line  = (r.edges_left == 5'h00);
            end else begin
               next_r.timer = r.timer + 32'h0000_0001;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         r.phase      <= S_IDLE;
         r.timer      <= 32'h0000_0000;
         r.edges_left <= 5'h00;
         r.last       <= pulse_status_pkg::ST_STROKE_OK;
         r.pending    <= pulse_status_pkg::ST_NONE;
         r.line       <= 1'b1;
         r.quiet_ok   <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   // R3 registered line
   assign link.status_line  = r.line;
   assign busy_out          = (r.phase != S_IDLE) || !r.quiet_ok;
   assign error_pending_out = (r.pending != pulse_status_pkg::ST_NONE);

endmodule : status_pulse_device

// file: test/status_link_monitor.sv
`timescale 1ns/1ps
module status_link_monitor #(
   parameter longint PHASE_CYCLES   = 10,
   parameter longint QUIET_CYCLES   = 30,
   parameter longint TIMEOUT_CYCLES = 2000
) (
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   input wire logic status_line,
   input wire logic cmd_valid,
   input wire logic cmd_status_request,
   input wire logic cmd_ack,
   input wire logic cmd_undefined
);
   // ----------------------------------------
   // Line history helpers
   // ----------------------------------------
   logic [31:0] run_len;
   logic [31:0] wait_cnt;
   logic [4:0]  edges;
   logic        line_q;
   logic        awaiting;
   logic        pending;
   logic        rise;
   logic        fall;
   logic        burst_end;

   assign rise      = status_line && !line_q;
   assign fall      = !status_line && line_q;
   assign burst_end = status_line && line_q && (run_len == 32'(2 * PHASE_CYCLES)) && (edges != 5'h00);

   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         run_len  <= 32'h0000_0000;
         wait_cnt <= 32'h0000_0000;
         edges    <= 5'h00;
         line_q   <= 1'b1;
         awaiting <= 1'b0;
         pending  <= 1'b0;
      end else begin
         line_q <= status_line;
         if (status_line != line_q) begin
            run_len <= 32'h0000_0001;
         end else if (run_len != 32'hFFFF_FFFF) begin
            run_len <= run_len + 32'h0000_0001;
         end
         if (burst_end) begin
            edges <= 5'h00;
         end else if (rise) begin
            edges <= edges + 5'h01;
         end
         if (cmd_valid) begin
            awaiting <= 1'b1;
         end else if (rise) begin
            awaiting <= 1'b0;
         end
         if (cmd_valid) begin
            pending  <= 1'b1;
            wait_cnt <= 32'h0000_0000;
         end else if (fall) begin
            pending <= 1'b0;
         end else if (pending) begin
            wait_cnt <= wait_cnt + 32'h0000_0001;
         end
      end
   end

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_low_len;
      rise |-> run_len == 32'(PHASE_CYCLES);
   endproperty
   property p_fall_gap;
      fall |-> (run_len == 32'(PHASE_CYCLES)) || (run_len >= 32'(QUIET_CYCLES));
   endproperty
   property p_idle_high;
      !status_line && !line_q |-> run_len < 32'(PHASE_CYCLES);
   endproperty
   property p_burst_count;
      burst_end |-> edges inside {5'h01, 5'h02, 5'h03, 5'h04, 5'h0C, 5'h0E, 5'h0F, 5'h10};
   endproperty
   property p_answer_bound;
      pending |-> wait_cnt < 32'(TIMEOUT_CYCLES);
   endproperty
   property p_solicited;
      fall && (run_len >= 32'(QUIET_CYCLES)) |-> pending;
   endproperty
   property p_cmd_quiet;
      cmd_valid |-> status_line && (run_len >= 32'(QUIET_CYCLES));
   endproperty
   property p_wait_resp;
      cmd_valid && !cmd_status_request |-> !awaiting;
   endproperty
   property p_cmd_pulse;
      cmd_valid |=> !cmd_valid ##1 !cmd_valid;
   endproperty
   property p_cmd_kind;
      cmd_valid |-> $onehot0({cmd_status_request, cmd_ack, cmd_undefined});
   endproperty

   a_low_len: assert property (p_low_len) else $error("low phase length wrong");
   a_fall_gap: assert property (p_fall_gap) else $error("pulse spacing wrong");
   a_idle_high: assert property (p_idle_high) else $error("line low too long");
   a_burst_count: assert property (p_burst_count) else $error("illegal edge count");
   a_answer_bound: assert property (p_answer_bound) else $error("response too late");
   a_solicited: assert property (p_solicited) else $error("response without command");
   a_cmd_quiet: assert property (p_cmd_quiet) else $error("command during quiet time");
   a_wait_resp: assert property (p_wait_resp) else $error("command before response");
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("command pulse too long");
   a_cmd_kind: assert property (p_cmd_kind) else $error("command kind ambiguous");

   c_undefined: cover property (burst_end && edges == 5'h10);
   c_overpressure: cover property (burst_end && edges == 5'h04);
   c_ack: cover property (cmd_valid && cmd_ack);
   c_probe: cover property (cmd_valid && cmd_status_request);
endmodule : status_link_monitor

// file: test/pulse_count_status_output_test.sv
`timescale 1ns/1ps
module pulse_count_status_output_test;
   logic                      sys_clk_in        = 1'b0;
   logic                      arst_n_in         = 1'b0;
   logic                      dev_arst_n        = 1'b0;
   logic                      action_done_in    = 1'b0;
   pulse_status_pkg::status_t action_status_in  = pulse_status_pkg::ST_STROKE_OK;
   logic                      refill_done_in    = 1'b0;
   logic                      ack_check_ok_in   = 1'b1;
   logic                      send_in           = 1'b0;
   logic                      kind_status_in    = 1'b0;
   logic                      kind_ack_in       = 1'b0;
   logic                      kind_undefined_in = 1'b0;
   logic                      busy_out;
   logic                      error_pending_out;
   logic                      ready_out;
   logic                      result_valid_out;
   pulse_status_pkg::status_t result_out;
   logic [4:0]                edge_count_out;
   logic                      timeout_out;
   logic                      link_lost_out;
   logic                      line_fault_out;
   int                        error_cnt         = 0;
   int                        tests_run         = 0;

   status_link_if link_bus ();

   status_pulse_device #(.PHASE_CYCLES(10), .QUIET_CYCLES(30)) status_pulse_device_inst (
      .sys_clk_in(sys_clk_in), .arst_n_in(dev_arst_n), .link(link_bus),
      .action_done_in(action_done_in), .action_status_in(action_status_in),
      .refill_done_in(refill_done_in), .ack_check_ok_in(ack_check_ok_in),
      .busy_out(busy_out), .error_pending_out(error_pending_out));

   status_pulse_controller #(.PHASE_CYCLES(10), .QUIET_CYCLES(30), .TIMEOUT_CYCLES(2000))
   status_pulse_controller_inst (
      .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .link(link_bus), .send_in(send_in),
      .kind_status_in(kind_status_in), .kind_ack_in(kind_ack_in), .kind_undefined_in(kind_undefined_in),
      .ready_out(ready_out), .result_valid_out(result_valid_out), .result_out(result_out),
      .edge_count_out(edge_count_out), .timeout_out(timeout_out), .link_lost_out(link_lost_out),
      .line_fault_out(line_fault_out));

   status_link_monitor status_link_monitor_inst (
      .sys_clk_in(sys_clk_in), .arst_n_in(dev_arst_n), .status_line(link_bus.status_line),
      .cmd_valid(link_bus.cmd_valid), .cmd_status_request(link_bus.cmd_status_request),
      .cmd_ack(link_bus.cmd_ack), .cmd_undefined(link_bus.cmd_undefined));

   always #5 sys_clk_in = ~sys_clk_in;

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic wrap_up();
      $display("Mismatches %0d, comparisons %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_up();
      error_cnt++;
      $display("[FAIL] %0t: wait limit reached", $time);
      wrap_up();
   endtask : give_up

   task automatic do_reset();
      @(posedge sys_clk_in);
      arst_n_in  <= 1'b0;
      dev_arst_n <= 1'b0;
      repeat (20) @(posedge sys_clk_in);
      arst_n_in  <= 1'b1;
      dev_arst_n <= 1'b1;
   endtask : do_reset

   // Kind: 0 action, 1 status request, 2 acknowledge, 3 undefined
   task automatic send(input logic [1:0] kind);
      int i;
      for (i = 0; i < 300 && ready_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 300) give_up();
      @(posedge sys_clk_in);
      send_in           <= 1'b1;
      kind_status_in    <= (kind == 2'h1);
      kind_ack_in       <= (kind == 2'h2);
      kind_undefined_in <= (kind == 2'h3);
      @(posedge sys_clk_in) send_in <= 1'b0;
   endtask : send

   task automatic expect_result(input pulse_status_pkg::status_t st, input logic [4:0] n);
      int i;
      for (i = 0; i < 1000 && result_valid_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 1000) give_up();
      check(8'(result_out), 8'(st));
      check(8'(edge_count_out), 8'(n));
      @(negedge sys_clk_in);
   endtask : expect_result

   task automatic stroke(input pulse_status_pkg::status_t st, input logic [4:0] n);
      send(2'h0);
      repeat (5) @(posedge sys_clk_in);
      action_status_in <= st;
      action_done_in   <= 1'b1;
      @(posedge sys_clk_in) action_done_in <= 1'b0;
      expect_result(st, n);
   endtask : stroke

   task automatic query(input logic [1:0] kind, input pulse_status_pkg::status_t st, input logic [4:0] n);
      send(kind);
      expect_result(st, n);
   endtask : query

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_plain();
      stroke(pulse_status_pkg::ST_CANCELLED, 5'h01);
      check(8'(busy_out), 8'h01);
      stroke(pulse_status_pkg::ST_STROKE_OK, 5'h02);
      stroke(pulse_status_pkg::ST_SOON_EMPTY, 5'h03);
      query(2'h1, pulse_status_pkg::ST_SOON_EMPTY, 5'h03);
   endtask : t_plain

   task automatic t_undefined();
      int i;
      for (i = 0; i < 300 && ready_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 300) give_up();
      check(8'(busy_out), 8'h00);
      query(2'h3, pulse_status_pkg::ST_UNDEFINED, 5'h10);
   endtask : t_undefined

   task automatic t_overpressure();
      stroke(pulse_status_pkg::ST_OVERPRESSURE, 5'h04);
      check(8'(error_pending_out), 8'h01);
      query(2'h0, pulse_status_pkg::ST_OVERPRESSURE, 5'h04);
      query(2'h2, pulse_status_pkg::ST_STROKE_OK, 5'h02);
      check(8'(error_pending_out), 8'h00);
   endtask : t_overpressure

   task automatic t_supply();
      @(posedge sys_clk_in) ack_check_ok_in <= 1'b0;
      stroke(pulse_status_pkg::ST_SUPPLY, 5'h0E);
      query(2'h2, pulse_status_pkg::ST_SUPPLY, 5'h0E);
      @(posedge sys_clk_in) ack_check_ok_in <= 1'b1;
      query(2'h2, pulse_status_pkg::ST_STROKE_OK, 5'h02);
   endtask : t_supply

   task automatic t_empty();
      stroke(pulse_status_pkg::ST_EMPTY, 5'h0C);
      query(2'h1, pulse_status_pkg::ST_EMPTY, 5'h0C);
      @(posedge sys_clk_in) refill_done_in <= 1'b1;
      @(posedge sys_clk_in) refill_done_in <= 1'b0;
      stroke(pulse_status_pkg::ST_STROKE_OK, 5'h02);
   endtask : t_empty

   task automatic t_internal();
      stroke(pulse_status_pkg::ST_INTERNAL, 5'h0F);
      query(2'h1, pulse_status_pkg::ST_INTERNAL, 5'h0F);
   endtask : t_internal

   task automatic t_timeout();
      int i;
      do_reset();
      // Silent far end: device held in reset over the command
      @(posedge sys_clk_in) dev_arst_n <= 1'b0;
      send(2'h0);
      repeat (20) @(posedge sys_clk_in);
      dev_arst_n <= 1'b1;
      for (i = 0; i < 2500 && timeout_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 2500) give_up();
      check(8'(link_lost_out), 8'h00);
      expect_result(pulse_status_pkg::ST_STROKE_OK, 5'h02);
      check(8'(timeout_out), 8'h00);
      check(8'(line_fault_out), 8'h00);
      // Device silent through command and probe
      @(posedge sys_clk_in) dev_arst_n <= 1'b0;
      send(2'h0);
      for (i = 0; i < 4500 && link_lost_out !== 1'b1; i++) @(negedge sys_clk_in);
      if (i == 4500) give_up();
      check(8'(timeout_out), 8'h01);
      do_reset();
   endtask : t_timeout

   initial begin
      do_reset();
      t_plain();
      t_undefined();
      t_overpressure();
      t_supply();
      t_empty();
      t_internal();
      t_timeout();
      wrap_up();
   end
endmodule : pulse_count_status_output_test
